// ### vram_host_pkg.sv
// Package for the video DRAM host controller: register map, cycle codes, pin bundles.
// Assumes a 10 MHz system clock and a dual-port video DRAM on the far side of the pins.
package vram_host_pkg;

  // ---------------------------------------------------------------
  // Software register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ROW    = 4'h1;
  localparam logic [3:0] REG_COL    = 4'h2;
  localparam logic [3:0] REG_WDATA  = 4'h3;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_RDATA  = 4'h6;
  localparam logic [3:0] REG_SER    = 4'h7;
  localparam logic [3:0] REG_SDATA  = 4'h8;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          CMD_MASK_BIT  = 4;
  localparam int          CMD_LATE_BIT  = 5;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_CONV_BIT   = 1;
  localparam int          ST_DIR_BIT    = 2;
  localparam int          ST_HALF_BIT   = 3;
  localparam int          ST_ERR_BIT    = 4;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing: each strobe phase lasts a fixed time.
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int PHASE_NS      = 100;
  localparam int PHASE_CYC     = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SER_HALF_NS   = 100;
  localparam int SER_HALF_CYC  = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // Cycle codes written to the command register
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ   = 4'h0,
    OP_WRITE  = 4'h1,
    OP_LOADCR = 4'h2,
    OP_READCR = 4'h3,
    OP_FLASH  = 4'h4,
    OP_BLOCK  = 4'h5,
    OP_RDXFER = 4'h6,
    OP_WRXFER = 4'h7,
    OP_SRXFER = 4'h8,
    OP_SWXFER = 4'h9
  } op_t;

  typedef struct packed {
    logic       row_strobe_n;
    logic       col_strobe_n;
    logic       write_strobe_n;
    logic       transfer_oe_n;
    logic       special_func_in;
    logic [8:0] addr;
    logic [7:0] data_out;
    logic       data_oe;
  } ram_pins_t;

  typedef struct packed {
    logic       serial_clk;
    logic       serial_en_n;
    logic [7:0] serial_out;
    logic       serial_oe;
  } ser_pins_t;

endpackage

// ### vram_host.sv
// Host controller that runs RAM-port cycles and the serial port of a video DRAM.
// Assumes software drives the plain register port; pins go straight to the device.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns

// How it works
// - Row address stands at row strobe fall, column address at column strobe fall.
// - Write low at row strobe fall loads mask from data pins.
// - Colour read keeps write strobe high from column fall to cycle end.
// - A conventional transfer must precede any split transfer.
// - Levels at row strobe fall and function input at column fall select operation.
module vram_host
  import vram_host_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic [3:0]                addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output      logic [31:0]               rdata,
  output      vram_host_pkg::ram_pins_t  ram_pins,
  input  wire logic [7:0]                data_in,
  output      vram_host_pkg::ser_pins_t  ser_pins,
  input  wire logic [7:0]                serial_in,
  input  wire logic                      half_indicator
);
  import vram_host_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ROW  = 7'b0000010,
    S_COL  = 7'b0000100,
    S_WE   = 7'b0001000,
    S_HOLD = 7'b0010000,
    S_END  = 7'b0100000,
    S_PRE  = 7'b1000000
  } st_t;

  typedef struct packed {
    st_t         st;
    op_t         op;
    logic        masked;
    logic        late;
    logic [8:0]  row;
    logic [8:0]  col;
    logic [7:0]  wdat;
    logic [7:0]  mask;
    logic [7:0]  rdat;
    logic [3:0]  cnt;
    logic        conv_done;
    logic        dir_in;
    logic        err;
    logic        ser_go;
    logic        ser_en;
    logic [9:0]  ser_left;
    logic [3:0]  ser_cnt;
    logic [7:0]  sdat_out;
    logic [7:0]  sdat_in;
    logic [2:0]  half_sync;
    logic        half_q;
    ram_pins_t   ram;
    ser_pins_t   ser;
    logic [31:0] rdata;
  } state_t;

  logic [1:0] rs_q;
  state_t     s_q;
  state_t     s_d;

  function automatic logic is_write_op(input op_t o);
    return (o == OP_WRITE) || (o == OP_LOADCR) || (o == OP_FLASH) || (o == OP_BLOCK)
        || (o == OP_WRXFER) || (o == OP_SWXFER);
  endfunction

  function automatic logic is_xfer(input op_t o);
    return (o == OP_RDXFER) || (o == OP_WRXFER) || (o == OP_SRXFER) || (o == OP_SWXFER);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.half_sync = {s_q.half_sync[1:0], half_indicator};
    if (s_q.half_sync[2] == s_q.half_sync[1]) begin
      s_d.half_q = s_q.half_sync[2];
    end

    // Software port.
    if (rd) begin
      unique case (addr)
        REG_STATUS: s_d.rdata = {27'h0, s_q.err, s_q.half_q, s_q.dir_in, s_q.conv_done,
                                 (s_q.st != S_IDLE) || s_q.ser_go};
        REG_RDATA:  s_d.rdata = {24'h0, s_q.rdat};
        REG_SDATA:  s_d.rdata = {24'h0, s_q.sdat_in};
        REG_ROW:    s_d.rdata = {23'h0, s_q.row};
        REG_COL:    s_d.rdata = {23'h0, s_q.col};
        REG_MASK:   s_d.rdata = {24'h0, s_q.mask};
        default:    s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (addr)
        REG_ROW:   s_d.row = wdata[8:0];
        REG_COL:   s_d.col = wdata[8:0];
        REG_WDATA: s_d.wdat = wdata[7:0];
        REG_MASK:  s_d.mask = wdata[7:0];
        REG_SDATA: s_d.sdat_out = wdata[7:0];
        REG_SER: begin
          if (!s_q.ser_go) begin
            s_d.ser_go   = 1'b1;
            s_d.ser_left = wdata[9:0];
            s_d.ser_en   = wdata[16];
            s_d.ser_cnt  = 4'h0;
          end
        end
        REG_CMD: begin
          if (s_q.st == S_IDLE) begin
            if ((op_t'(wdata[3:0]) == OP_SRXFER || op_t'(wdata[3:0]) == OP_SWXFER)
                && !s_q.conv_done) begin
              s_d.err = 1'b1;
            end else begin
              s_d.op     = op_t'(wdata[3:0]);
              s_d.masked = wdata[CMD_MASK_BIT];
              s_d.late   = wdata[CMD_LATE_BIT];
              s_d.err    = 1'b0;
              s_d.st     = S_PRE;
              s_d.cnt    = 4'h0;
            end
          end
        end
        default: ;
      endcase
    end

    // RAM-port cycle sequencer.
    unique case (s_q.st)
      S_IDLE: ;
      S_PRE: begin
        s_d.ram.addr            = s_q.row;
        s_d.ram.col_strobe_n    = 1'b1;
        s_d.ram.transfer_oe_n   = !is_xfer(s_q.op);
        s_d.ram.special_func_in = (s_q.op == OP_LOADCR) || (s_q.op == OP_READCR)
                               || (s_q.op == OP_FLASH) || (s_q.op == OP_SRXFER)
                               || (s_q.op == OP_SWXFER);
        s_d.ram.write_strobe_n  = !(s_q.masked || s_q.op == OP_WRXFER
                                 || s_q.op == OP_SWXFER || s_q.op == OP_FLASH);
        s_d.ram.data_out        = s_q.mask;
        s_d.ram.data_oe         = !s_d.ram.write_strobe_n;
        s_d.st  = S_ROW;
        s_d.cnt = 4'h0;
      end
      S_ROW: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'h0) begin
          s_d.ram.row_strobe_n = 1'b0;
        end else if (s_q.cnt >= 4'(PHASE_CYC)) begin
          s_d.ram.write_strobe_n = 1'b1;
          s_d.ram.data_oe        = 1'b0;
          s_d.ram.addr = (s_q.op == OP_BLOCK) ? {s_q.col[8:2], 2'b00} : s_q.col;
          s_d.ram.special_func_in = (s_q.op == OP_BLOCK) || (s_q.op == OP_LOADCR);
          if (s_q.op == OP_BLOCK) begin
            s_d.ram.data_out = s_q.wdat;
            s_d.ram.data_oe  = 1'b1;
          end else if (is_write_op(s_q.op) && !s_q.late && !is_xfer(s_q.op)) begin
            s_d.ram.write_strobe_n = 1'b0;
            s_d.ram.data_out = s_q.wdat;
            s_d.ram.data_oe  = 1'b1;
          end else begin
            s_d.ram.transfer_oe_n = is_xfer(s_q.op) || is_write_op(s_q.op);
          end
          s_d.st  = S_COL;
          s_d.cnt = 4'h0;
        end
      end
      S_COL: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'h0) begin
          s_d.ram.col_strobe_n = 1'b0;
        end else if (s_q.cnt >= 4'(PHASE_CYC)) begin
          s_d.st  = S_WE;
          s_d.cnt = 4'h0;
          if (is_write_op(s_q.op) && s_q.late && !is_xfer(s_q.op)) begin
            s_d.ram.data_out = s_q.wdat;
            s_d.ram.data_oe  = 1'b1;
          end
        end
      end
      S_WE: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt == 4'h0 && is_write_op(s_q.op) && s_q.late && !is_xfer(s_q.op)) begin
          s_d.ram.write_strobe_n = 1'b0;
        end else if (s_q.cnt >= 4'(PHASE_CYC)) begin
          s_d.rdat = data_in;
          s_d.st   = S_HOLD;
          s_d.cnt  = 4'h0;
        end
      end
      S_HOLD: begin
        s_d.ram.row_strobe_n   = 1'b1;
        s_d.ram.col_strobe_n   = 1'b1;
        s_d.ram.write_strobe_n = 1'b1;
        s_d.ram.transfer_oe_n  = 1'b1;
        s_d.ram.data_oe        = 1'b0;
        if (s_q.op == OP_RDXFER || s_q.op == OP_WRXFER) begin
          s_d.conv_done = 1'b1;
          s_d.dir_in    = (s_q.op == OP_WRXFER);
        end
        s_d.st = S_END;
      end
      S_END: begin
        s_d.cnt = s_q.cnt + 4'h1;
        if (s_q.cnt >= 4'(PHASE_CYC)) begin
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    // Serial clock generator; held while a full transfer runs.
    if (s_q.ser_go && !(is_xfer(s_q.op) && s_q.st != S_IDLE
        && s_q.op != OP_SRXFER && s_q.op != OP_SWXFER)) begin
      s_d.ser_cnt = s_q.ser_cnt + 4'h1;
      s_d.ser.serial_en_n = !s_q.ser_en;
      s_d.ser.serial_oe   = s_q.dir_in && s_q.ser_en;
      s_d.ser.serial_out  = s_q.sdat_out;
      if (s_q.ser_cnt >= 4'(SER_HALF_CYC)) begin
        s_d.ser_cnt = 4'h0;
        s_d.ser.serial_clk = !s_q.ser.serial_clk;
        if (!s_q.ser.serial_clk) begin
          s_d.ser_left = s_q.ser_left - 10'h001;
        end else begin
          if (!s_q.dir_in) begin
            s_d.sdat_in = serial_in;
          end
          if (s_q.ser_left == 10'h000) begin
            s_d.ser_go = 1'b0;
            s_d.ser.serial_en_n = 1'b1;
            s_d.ser.serial_oe   = 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rs_q <= 2'b00;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end

  always_ff @(posedge clock or negedge rs_q[1]) begin
    if (!rs_q[1]) begin
      s_q     <= '0;
      s_q.st  <= S_IDLE;
      s_q.op  <= OP_READ;
      s_q.ram <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_strobe_n: 1'b1,
                   transfer_oe_n: 1'b1, special_func_in: 1'b0, addr: 9'h000,
                   data_out: 8'h00, data_oe: 1'b0};
      s_q.ser <= '{serial_clk: 1'b0, serial_en_n: 1'b1, serial_out: 8'h00, serial_oe: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata    = s_q.rdata;
  assign ram_pins = s_q.ram;
  assign ser_pins = s_q.ser;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  split_order_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    (s_q.st == S_ROW && (s_q.op == OP_SRXFER || s_q.op == OP_SWXFER)) |-> s_q.conv_done)
    else $error("Split transfer issued before a conventional one.");
  col_after_row_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    $fell(s_q.ram.col_strobe_n) |-> !s_q.ram.row_strobe_n)
    else $error("Column strobe fell without row strobe low.");
  block_addr_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    ($fell(s_q.ram.col_strobe_n) && s_q.op == OP_BLOCK) |-> s_q.ram.addr[1:0] == 2'b00)
    else $error("Block write column low bits not zero.");
  read_oe_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    (s_q.st == S_WE && s_q.op == OP_READ) |-> (!s_q.ram.transfer_oe_n && !s_q.ram.data_oe))
    else $error("Read cycle without output enable.");
  early_we_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    ($fell(s_q.ram.col_strobe_n) && s_q.op == OP_WRITE && !s_q.late)
      |-> !s_q.ram.write_strobe_n)
    else $error("Early write strobe not low at column strobe.");
  late_we_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    ($fell(s_q.ram.write_strobe_n) && s_q.late && !s_q.ram.row_strobe_n)
      |-> !s_q.ram.col_strobe_n)
    else $error("Late write strobe fell before column strobe.");
  mask_drive_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    ($fell(s_q.ram.row_strobe_n) && !s_q.ram.write_strobe_n) |-> s_q.ram.data_oe)
    else $error("Mask not driven at row strobe fall.");
  dir_keep_a: assert property (@(posedge clock) disable iff (!rs_q[1])
    (s_q.st == S_HOLD && (s_q.op == OP_SRXFER || s_q.op == OP_SWXFER))
      |=> $stable(s_q.dir_in))
    else $error("Split transfer changed serial direction.");
endmodule

// ### vram_dev_model.sv
// Behavioural dual-port video DRAM that answers the host controller's pins.
// Assumes pins change only after host clock edges; unwritten cells read as zero.
`timescale 1ns/1ns
module vram_dev_model
  import vram_host_pkg::*;
(
  input  wire vram_host_pkg::ram_pins_t ram_pins,
  input  wire vram_host_pkg::ser_pins_t ser_pins,
  output      logic [7:0]               data_in,
  output      logic [7:0]               serial_in,
  output      logic                     half_indicator
);
  import vram_host_pkg::*;
  // ---------------------------------------------------------------
  // Array state and strobe decode
  // ---------------------------------------------------------------
  logic [7:0] mem [int];
  logic [7:0] serial_access_memory [512];
  logic [7:0] colour = 8'h00, wmask = 8'hFF, last_d = 8'h00, last_s = 8'h00;
  logic [8:0] row, col, ptr = 9'h000, tap2 = 9'h000;
  logic       we_r, dsf_r, trg_r, cas_r, dsf_c, col_on = 1'b0, dir_in = 1'b0, split = 1'b0;
  wire        ras_n = ram_pins.row_strobe_n;
  wire        cas_n = ram_pins.col_strobe_n;
  wire        we_n  = ram_pins.write_strobe_n;
  wire        rd_on = !ras_n && col_on && !cas_n && we_n && !ram_pins.transfer_oe_n && trg_r;
  function automatic logic [7:0] rdm(input logic [8:0] cc);
    return mem.exists(int'({row, cc})) ? mem[int'({row, cc})] : 8'h00;
  endfunction
  task automatic wrm(input logic [8:0] cc, input logic [7:0] dd);
    mem[int'({row, cc})] = (rdm(cc) & ~wmask) | (dd & wmask);
  endtask
  task automatic xfer(input int base, input int n);
    for (int k = base; k < base + n; k++)
      if (we_r) serial_access_memory[k] = rdm(9'(k));
      else wrm(9'(k), serial_access_memory[k]);
  endtask
  always @(negedge ras_n) begin
    row = ram_pins.addr;
    {cas_r, trg_r, we_r, dsf_r} = {cas_n, ram_pins.transfer_oe_n, we_n, ram_pins.special_func_in};
    wmask = we_n ? 8'hFF : ram_pins.data_out;
    col_on = 1'b0;
    if (cas_r && trg_r && !we_r && dsf_r)
      for (int k = 0; k < 512; k++) wrm(9'(k), colour);
  end
  always @(negedge cas_n) if (!ras_n && cas_r) begin
    col = ram_pins.addr;
    dsf_c = ram_pins.special_func_in;
    col_on = 1'b1;
    if (!trg_r && !dsf_r) begin
      {split, dir_in, ptr} = {1'b0, !we_r, col};
      xfer(0, 512);
    end else if (!trg_r) begin
      {split, tap2} = {1'b1, ~ptr[8], col[7:0]};
      xfer(int'(tap2[8]) * 256, 256);
    end else if (dsf_r) begin
      if (we_r && !we_n) colour = ram_pins.data_out;
    end else if (dsf_c) begin
      for (int i = 0; i < 4; i++)
        if (ram_pins.data_out[i]) wrm({col[8:2], 2'(i)}, colour);
    end else if (!we_n) wrm(col, ram_pins.data_out);
  end
  always @(negedge we_n) if (!ras_n && col_on && trg_r) begin
    if (dsf_r && we_r) colour = ram_pins.data_out;
    else if (!dsf_r && !dsf_c) wrm(col, ram_pins.data_out);
  end
  always @* if (rd_on) last_d = dsf_r ? colour : rdm(col);
  assign data_in = rd_on ? last_d : ~last_d;
  // ---------------------------------------------------------------
  // Serial side
  // ---------------------------------------------------------------
  always @(posedge ser_pins.serial_clk) begin
    if (!ser_pins.serial_en_n && dir_in) serial_access_memory[ptr] = ser_pins.serial_out;
    if (!ser_pins.serial_en_n && !dir_in) last_s = serial_access_memory[ptr];
    if (split && ptr[7:0] == 8'hFF) ptr = tap2;
    else ptr = ptr + 9'h001;
  end
  assign serial_in = (!dir_in && !ser_pins.serial_en_n) ? last_s : ~last_s;
  assign half_indicator = split ? ptr[8] : 1'b0;
endmodule

// ### vram_host_tb_top.sv
// Self-checking bench for the video DRAM host controller driving a device model.
// Assumes the device model answers every pin; registers go over the plain port.
`timescale 1ns/1ns
module vram_host_tb_top;
  import vram_host_pkg::*;
  // ---------------------------------------------------------------
  // Signals, design and device
  // ---------------------------------------------------------------
  logic        clock = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  ram_pins_t   ram_pins;
  ser_pins_t   ser_pins;
  logic [7:0]  data_in, serial_in, d, m, c1, sh [int];
  logic        half_indicator;
  logic [8:0]  r, c;
  int          miscompares = 0, n_checks = 0, seed = 77434;
  int          cl [7] = '{0, 510, 511, 264, 265, 266, 267};
  always #50 clock = ~clock;
  vram_host i_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ram_pins(ram_pins), .data_in(data_in), .ser_pins(ser_pins),
    .serial_in(serial_in), .half_indicator(half_indicator));
  vram_dev_model i_dev (.ram_pins(ram_pins), .ser_pins(ser_pins), .data_in(data_in),
    .serial_in(serial_in), .half_indicator(half_indicator));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] dd);
    @(posedge clock);
    {addr, wdata, wr} <= {a, dd, 1'b1};
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] dd);
    @(posedge clock);
    {addr, rd} <= {a, 1'b1};
    @(posedge clock);
    rd <= 1'b0;
    #1 dd = rdata;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      bus_rd(REG_STATUS, v);
      if (v[ST_BUSY_BIT] === 1'b0) return;
    end
    miscompares++;
    give_verdict();
  endtask
  task automatic op(input op_t o, input logic [8:0] rr, input logic [8:0] cc,
                    input logic [31:0] dd, input logic [1:0] fl);
    bus_wr(REG_ROW, {23'h0, rr});
    bus_wr(REG_COL, {23'h0, cc});
    bus_wr(REG_WDATA, dd);
    bus_wr(REG_CMD, {26'h0, fl, o});
    wait_idle();
  endtask
  function automatic void put(input logic [8:0] cc, input logic [7:0] dd, input logic [7:0] mm);
    logic [7:0] old;
    old = sh.exists(int'({r, cc})) ? sh[int'({r, cc})] : 8'h00;
    sh[int'({r, cc})] = (old & ~mm) | (dd & mm);
  endfunction
  task automatic rd_cell(input logic [8:0] cc, input string what);
    op(OP_READ, r, cc, 32'h0, 2'b00);
    bus_rd(REG_RDATA, v);
    chk(what, {24'h0, sh[int'({r, cc})]}, v & 32'hFF);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    op(OP_SRXFER, 9'h0, 9'h0, 32'h0, 2'b00);
    bus_rd(REG_STATUS, v);
    chk("split_err", 32'h1, 32'(v[ST_ERR_BIT]));
    $display("test split_order done");
    for (int i = 0; i < 8; i++) begin
      {r, c, d} = {9'($random(seed)), 9'($random(seed)), 8'($random(seed))};
      op(OP_WRITE, r, c, {24'h0, d}, {i[0], 1'b0});
      put(c, d, 8'hFF);
      rd_cell(c, "cell");
      m = (i < 2) ? 8'(i * 255) : 8'($random(seed));
      bus_wr(REG_MASK, {24'h0, m});
      op(OP_WRITE, r, c, {24'h0, ~d}, {i[0], 1'b1});
      put(c, ~d, m);
      rd_cell(c, "masked");
      c1 = 8'($random(seed));
      op(OP_LOADCR, r, c, {24'h0, c1}, {i[0], 1'b0});
      op(OP_READCR, r, c, 32'h0, 2'b00);
      bus_rd(REG_RDATA, v);
      chk("colour", {24'h0, c1}, v & 32'hFF);
      rd_cell(c, "refresh");
    end
    $display("test ram_cycles done");
    for (int j = 0; j < 2; j++) begin
      m = (j == 0) ? 8'hFF : 8'($random(seed));
      bus_wr(REG_MASK, {24'h0, m});
      op(OP_FLASH, r, 9'h0, 32'h0, 2'b01);
      foreach (cl[k]) put(9'(cl[k]), c1, m);
      foreach (cl[k]) rd_cell(9'(cl[k]), "flash");
      c1 = 8'($random(seed));
      op(OP_LOADCR, r, 9'h0, {24'h0, c1}, 2'b00);
    end
    for (int j = 0; j < 2; j++) begin
      op(OP_BLOCK, r, 9'h10B, (j == 0) ? 32'hB : 32'h6, {1'b0, j[0]});
      for (int i = 0; i < 4; i++)
        if ((j == 0) ? i != 2 : (i == 1 || i == 2)) put(9'(264 + i), c1, (j == 0) ? 8'hFF : m);
      for (int i = 3; i < 7; i++) rd_cell(9'(cl[i]), "block");
    end
    $display("test colour_writes done");
    op(OP_RDXFER, r, 9'd510, 32'h0, 2'b00);
    bus_rd(REG_STATUS, v);
    chk("dir_out", 32'h2, v & 32'h6);
    for (int k = 0; k < 3; k++) begin
      bus_wr(REG_SER, (k == 1) ? 32'h0000_0001 : 32'h0001_0001);
      wait_idle();
      bus_rd(REG_SDATA, v);
      if (k != 1) chk("serial", {24'h0, sh[int'({r, (k == 0) ? 9'd510 : 9'd0})]}, v & 32'hFF);
    end
    op(OP_WRXFER, r, 9'h0, 32'h0, 2'b00);
    bus_rd(REG_STATUS, v);
    chk("dir_in", 32'h1, 32'(v[ST_DIR_BIT]));
    d = 8'($random(seed));
    bus_wr(REG_SDATA, {24'h0, d});
    bus_wr(REG_SER, 32'h0001_0001);
    wait_idle();
    op(OP_WRXFER, r, 9'h0, 32'h0, 2'b00);
    put(9'h0, d, m);
    rd_cell(9'h0, "serial_wr");
    op(OP_SRXFER, r, 9'h0, 32'h0, 2'b00);
    bus_rd(REG_STATUS, v);
    chk("split_dir", 32'h1, 32'(v[ST_DIR_BIT]));
    chk("half", 32'h0, 32'(v[ST_HALF_BIT]));
    $display("test transfers done");
    give_verdict();
  end
endmodule
